// ===== core/jtp_regs.svh
/*
 Constants of the test access port: instruction codes, capture
 patterns, register lengths and reset values.
 Assumes inclusion by the controller module and by the port top module.
*/
// Functional notes
// - all port state changes, shifting and capture are clocked by the test clock
// - no test reset pin; reset comes from power-on, fuse or mode select
// - fuse unprogrammed: pins are ordinary port pins, controller held in reset
// - fuse programmed: weak pull-ups on mode select, clock, data in; port enabled
// - sixteen-state controller; mode select at rising clock picks each transition
// - after power-on the controller starts in Test-Logic-Reset
// - every shift register shifts least significant bit in and out first
// - during instruction shift the captured pattern 0x01 leaves on data out
// - sequence 1,1,0 returns to idle; instruction latched in Update-IR
// - current instruction selects the data register between data in and out
// - data shift sends out values captured in Capture-DR
// - latched parallel data outputs change only in Update-DR
// - exit, pause and exit2 states do nothing but wait or pass
// - idle need not separate scans; some instructions act in idle
// - five rising clocks with mode select high always reach Test-Logic-Reset
// - board-test data registers are identification, bypass and boundary chain
`ifndef JTP_REGS_SVH
`define JTP_REGS_SVH

`define JTP_IR_WIDTH     4
`define JTP_IR_CAPTURE   4'h1
`define JTP_INS_EXTEST   4'h0
`define JTP_INS_IDCODE   4'h1
`define JTP_INS_SAMPLE   4'h2
`define JTP_INS_BYPASS   4'hF
`define JTP_ID_WIDTH     32
// identification value is arbitrary
`define JTP_IDCODE_DEF   32'h0A5C_3001
`define JTP_BSR_LEN      8
`define JTP_RESET_ONES   3'h5

`endif

// ===== core/jtp_pkg.sv
/*
 Types of the test access port: controller states, register
 selection and signal groups.
 Assumes jtp_regs.svh on the include path.
*/
package jtp_pkg;

	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE,
		ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
		ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
		ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} jtp_state_type;

	typedef enum logic [1:0] {SEL_BYPASS, SEL_IDCODE, SEL_BOUNDARY} jtp_sel_type;

	typedef struct packed {
		logic tms;
		logic tdi;
	} jtp_pins_type;

	typedef struct packed {
		logic cap_ir;
		logic shift_ir;
		logic upd_ir;
		logic cap_dr;
		logic shift_dr;
		logic upd_dr;
		logic in_reset;
		logic in_idle;
	} jtp_dec_type;

endpackage : jtp_pkg

// ===== core/jtp_sync.sv
/*
 Two-stage level synchroniser, one per bit.
 Assumes each bit is an independent level.
*/
`timescale 1ns/10ps
`default_nettype none

module jtp_sync
	import jtp_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta;

	generate
		if (W < 1) begin : g_bad_width
			$error("jtp_sync: width must be at least one");
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : jtp_sync

`default_nettype wire

// ===== core/jtp_fsm.sv
/*
 Sixteen-state test access port controller with state decode.
 Assumes mode select is stable around the rising test clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "jtp_regs.svh"

module jtp_fsm
	import jtp_pkg::*;
(
	input  wire logic          tck,
	input  wire logic          rst,
	input  wire logic          en,
	input  wire logic          force_reset,
	input  wire logic          tms,
	output var  jtp_state_type state,
	output var  jtp_dec_type   dec
);

	jtp_state_type next_state;
	logic [2:0]    ones_cnt;

	// ----------------------------------------
	// transitions
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_RESET:    next_state = tms ? ST_RESET : ST_IDLE;
			ST_IDLE:     next_state = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR:   next_state = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR:   next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR:   next_state = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR:   next_state = tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR:   next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR:   next_state = tms ? ST_SEL_DR : ST_IDLE;
			default:     next_state = ST_RESET;
		endcase
	end

	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			state <= ST_RESET;
		end else if (en) begin
			if (force_reset) begin
				state <= ST_RESET;
			end else begin
				state <= next_state;
			end
		end
	end

	assign dec = '{
		cap_ir:   (state == ST_CAP_IR),
		shift_ir: (state == ST_SHIFT_IR),
		upd_ir:   (state == ST_UPD_IR),
		cap_dr:   (state == ST_CAP_DR),
		shift_dr: (state == ST_SHIFT_DR),
		upd_dr:   (state == ST_UPD_DR),
		in_reset: (state == ST_RESET),
		in_idle:  (state == ST_IDLE)
	};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			ones_cnt <= 3'h0;
		end else if (en) begin
			if (!tms) begin
				ones_cnt <= 3'h0;
			end else if (ones_cnt < `JTP_RESET_ONES) begin
				ones_cnt <= ones_cnt + 3'h1;
			end
		end
	end

	property p_five_ones;
		@(posedge tck) disable iff (rst)
		(ones_cnt >= `JTP_RESET_ONES) |-> (state == ST_RESET);
	endproperty
	a_five_ones: assert property (p_five_ones) else $error("five high mode selects did not reset");

	property p_idle_exit;
		@(posedge tck) disable iff (rst)
		(state == ST_IDLE) && tms && en && !force_reset |=> (state == ST_SEL_DR);
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("idle did not move to select-dr");

	property p_reset_hold;
		@(posedge tck) disable iff (rst)
		(state == ST_RESET) && tms && en |=> (state == ST_RESET) [*1] ##0 dec.in_reset;
	endproperty
	a_reset_hold: assert property (p_reset_hold) else $error("reset state left with mode select high");

endmodule : jtp_fsm

`default_nettype wire

// ===== core/jtp_tap.sv
/*
 Test access port top: controller, instruction register, data
 registers (identification, bypass, boundary chain), data out on the
 falling test clock, and the crossing of results to the system clock.
 Assumes the test clock comes from the external controller and may
 stop between scans; the system clock runs free.
*/
`timescale 1ns/10ps
`default_nettype none
`include "jtp_regs.svh"

module jtp_tap
	import jtp_pkg::*;
#(
	parameter int          IR_W    = `JTP_IR_WIDTH,
	parameter int          ID_W    = `JTP_ID_WIDTH,
	parameter int          BSR_LEN = `JTP_BSR_LEN,
	parameter logic [31:0] ID_CODE = `JTP_IDCODE_DEF
) (
	input  wire logic               clock,
	input  wire logic               sys_rst,
	input  wire logic               clk_en,
	input  wire logic               test_port_enable_fuse,
	input  wire logic               tck,
	input  wire logic               tms,
	input  wire logic               tdi,
	input  wire logic [BSR_LEN-1:0] bsr_pins,
	output var  logic               tdo_out,
	output var  logic               tdo_oe_n,
	output var  logic               tap_pullup_en,
	output var  logic               tap_pins_released,
	output var  logic [IR_W-1:0]    instr_active,
	output var  logic [BSR_LEN-1:0] bsr_drive,
	output var  logic               boundary_test_mode,
	output var  logic               tap_in_reset,
	output var  logic               run_idle_active
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	generate
		if (IR_W != `JTP_IR_WIDTH) begin : g_bad_ir
			$error("jtp_tap: instruction width is fixed at four");
		end
		if (ID_W != `JTP_ID_WIDTH) begin : g_bad_id
			$error("jtp_tap: identification width is fixed at 32");
		end
		if (BSR_LEN < 1) begin : g_bad_bsr
			$error("jtp_tap: boundary chain needs one cell at least");
		end
	endgenerate

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	jtp_pins_type       pins;
	jtp_state_type      state;
	jtp_dec_type        dec;
	jtp_sel_type        sel;
	logic               fuse_tck;
	logic               ce_tck;
	logic [BSR_LEN-1:0] bsr_pins_tck;
	logic [IR_W-1:0]    ir_shift;
	logic [IR_W-1:0]    ir;
	logic [ID_W-1:0]    id_shift;
	logic               byp;
	logic [BSR_LEN-1:0] bsr_shift;
	logic [BSR_LEN-1:0] bsr_hold;
	logic               next_tdo;
	logic               ir_tgl;
	logic               dr_tgl;
	logic               in_reset_q;
	logic               in_idle_q;
	logic               fuse_sys;
	logic               ir_tgl_s;
	logic               dr_tgl_s;
	logic               in_reset_s;
	logic               in_idle_s;
	logic               ir_tgl_d;
	logic               dr_tgl_d;

	// ----------------------------------------
	// instruction decode
	// ----------------------------------------
	function automatic jtp_sel_type sel_of(input logic [IR_W-1:0] ins);
		case (ins)
			`JTP_INS_IDCODE: sel_of = SEL_IDCODE;
			`JTP_INS_EXTEST: sel_of = SEL_BOUNDARY;
			`JTP_INS_SAMPLE: sel_of = SEL_BOUNDARY;
			default:         sel_of = SEL_BYPASS;
		endcase
	endfunction : sel_of

	assign sel  = sel_of(ir);
	assign pins = '{tms: tms, tdi: tdi};

	// ----------------------------------------
	// test clock domain
	// ----------------------------------------
	jtp_sync #(
		.W (2)
	) u_sync_tck (
		.clk (tck),
		.rst (sys_rst),
		.d   ({test_port_enable_fuse, clk_en}),
		.q   ({fuse_tck, ce_tck})
	);

	jtp_sync #(
		.W (BSR_LEN)
	) u_sync_bsr (
		.clk (tck),
		.rst (sys_rst),
		.d   (bsr_pins),
		.q   (bsr_pins_tck)
	);

	jtp_fsm u_fsm (
		.tck         (tck),
		.rst         (sys_rst),
		.en          (ce_tck),
		.force_reset (!fuse_tck),
		.tms         (pins.tms),
		.state       (state),
		.dec         (dec)
	);

	// instruction shift stage
	always_ff @(posedge tck or posedge sys_rst) begin
		if (sys_rst) begin
			ir_shift <= '0;
		end else if (ce_tck) begin
			if (dec.cap_ir) begin
				ir_shift <= `JTP_IR_CAPTURE;
			end else if (dec.shift_ir) begin
				ir_shift <= {pins.tdi, ir_shift[IR_W-1:1]};
			end
		end
	end

	// current instruction
	always_ff @(posedge tck or posedge sys_rst) begin
		if (sys_rst) begin
			ir <= `JTP_INS_IDCODE;
		end else if (ce_tck) begin
			if (dec.in_reset) begin
				ir <= `JTP_INS_IDCODE;
			end else if (dec.upd_ir) begin
				ir <= ir_shift;
			end
		end
	end

	// identification register
	always_ff @(posedge tck or posedge sys_rst) begin
		if (sys_rst) begin
			id_shift <= '0;
		end else if (ce_tck && sel == SEL_IDCODE) begin
			if (dec.cap_dr) begin
				id_shift <= ID_CODE;
			end else if (dec.shift_dr) begin
				id_shift <= {pins.tdi, id_shift[ID_W-1:1]};
			end
		end
	end

	// bypass stage
	always_ff @(posedge tck or posedge sys_rst) begin
		if (sys_rst) begin
			byp <= 1'b0;
		end else if (ce_tck && sel == SEL_BYPASS) begin
			if (dec.cap_dr) begin
				byp <= 1'b0;
			end else if (dec.shift_dr) begin
				byp <= pins.tdi;
			end
		end
	end

	// boundary chain shift stage
	always_ff @(posedge tck or posedge sys_rst) begin
		if (sys_rst) begin
			bsr_shift <= '0;
		end else if (ce_tck && sel == SEL_BOUNDARY) begin
			if (dec.cap_dr) begin
				bsr_shift <= bsr_pins_tck;
			end else if (dec.shift_dr) begin
				bsr_shift <= {pins.tdi, bsr_shift[BSR_LEN-1:1]};
			end
		end
	end

	// boundary chain latched outputs
	always_ff @(posedge tck or posedge sys_rst) begin
		if (sys_rst) begin
			bsr_hold <= '0;
		end else if (ce_tck && dec.upd_dr && sel == SEL_BOUNDARY) begin
			bsr_hold <= bsr_shift;
		end
	end

	// change toggles and state flags for the system side
	always_ff @(posedge tck or posedge sys_rst) begin
		if (sys_rst) begin
			ir_tgl     <= 1'b0;
			dr_tgl     <= 1'b0;
			in_reset_q <= 1'b1;
			in_idle_q  <= 1'b0;
		end else if (ce_tck) begin
			if (dec.upd_ir || (dec.in_reset && ir != `JTP_INS_IDCODE)) begin
				ir_tgl <= !ir_tgl;
			end
			if (dec.upd_dr && sel == SEL_BOUNDARY) begin
				dr_tgl <= !dr_tgl;
			end
			in_reset_q <= dec.in_reset;
			in_idle_q  <= dec.in_idle;
		end
	end

	// data out mux
	always_comb begin
		next_tdo = byp;
		if (dec.shift_ir) begin
			next_tdo = ir_shift[0];
		end else begin
			case (sel)
				SEL_IDCODE:   next_tdo = id_shift[0];
				SEL_BOUNDARY: next_tdo = bsr_shift[0];
				default:      next_tdo = byp;
			endcase
		end
	end

	// data out on the falling edge
	always_ff @(negedge tck or posedge sys_rst) begin
		if (sys_rst) begin
			tdo_out  <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (ce_tck) begin
			tdo_out  <= next_tdo;
			tdo_oe_n <= !(dec.shift_ir || dec.shift_dr);
		end
	end

	// ----------------------------------------
	// system clock domain
	// ----------------------------------------
	jtp_sync #(
		.W (5)
	) u_sync_sys (
		.clk (clock),
		.rst (sys_rst),
		.d   ({test_port_enable_fuse, ir_tgl, dr_tgl, in_reset_q, in_idle_q}),
		.q   ({fuse_sys, ir_tgl_s, dr_tgl_s, in_reset_s, in_idle_s})
	);

	// pin ownership
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			tap_pullup_en     <= 1'b0;
			tap_pins_released <= 1'b1;
		end else if (clk_en) begin
			tap_pullup_en     <= fuse_sys;
			tap_pins_released <= !fuse_sys;
		end
	end

	// instruction and boundary words, taken once their toggle lands
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ir_tgl_d           <= 1'b0;
			dr_tgl_d           <= 1'b0;
			instr_active       <= `JTP_INS_IDCODE;
			bsr_drive          <= '0;
			boundary_test_mode <= 1'b0;
		end else if (clk_en) begin
			ir_tgl_d <= ir_tgl_s;
			dr_tgl_d <= dr_tgl_s;
			if (ir_tgl_s != ir_tgl_d) begin
				instr_active       <= ir;
				boundary_test_mode <= (ir == `JTP_INS_EXTEST);
			end
			if (dr_tgl_s != dr_tgl_d) begin
				bsr_drive <= bsr_hold;
			end
		end
	end

	// controller state flags
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			tap_in_reset    <= 1'b1;
			run_idle_active <= 1'b0;
		end else if (clk_en) begin
			tap_in_reset    <= in_reset_s;
			run_idle_active <= in_idle_s;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_cap_ir;
		@(posedge tck) disable iff (sys_rst)
		dec.cap_ir && ce_tck |=> (ir_shift == `JTP_IR_CAPTURE);
	endproperty
	a_cap_ir: assert property (p_cap_ir) else $error("capture-ir did not load 0x01");

	property p_ir_lsb_first;
		@(posedge tck) disable iff (sys_rst)
		dec.shift_ir && ce_tck |=> (ir_shift == {$past(pins.tdi), $past(ir_shift[IR_W-1:1])});
	endproperty
	a_ir_lsb_first: assert property (p_ir_lsb_first) else $error("instruction not shifted lsb first");

	property p_ir_update;
		@(posedge tck) disable iff (sys_rst)
		ce_tck && $past(ce_tck) && !$stable(ir) |-> ($past(dec.upd_ir) || $past(dec.in_reset));
	endproperty
	a_ir_update: assert property (p_ir_update) else $error("instruction changed outside update-ir");

	property p_id_path;
		@(posedge tck) disable iff (sys_rst)
		dec.shift_dr && ce_tck && (sel == SEL_IDCODE)
			|=> (id_shift == {$past(pins.tdi), $past(id_shift[ID_W-1:1])});
	endproperty
	a_id_path: assert property (p_id_path) else $error("identification path not shifting");

	property p_bypass_zero;
		@(posedge tck) disable iff (sys_rst)
		dec.cap_dr && ce_tck && (sel == SEL_BYPASS) |=> !byp;
	endproperty
	a_bypass_zero: assert property (p_bypass_zero) else $error("bypass did not capture zero");

	property p_bsr_hold;
		@(posedge tck) disable iff (sys_rst)
		ce_tck && $past(ce_tck) && !$stable(bsr_hold) |-> $past(dec.upd_dr);
	endproperty
	a_bsr_hold: assert property (p_bsr_hold) else $error("boundary outputs changed outside update-dr");

	property p_wait_states;
		@(posedge tck) disable iff (sys_rst)
		(state inside {ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR})
			|=> $stable(ir_shift) && $stable(bsr_shift) && $stable(id_shift) && $stable(ir);
	endproperty
	a_wait_states: assert property (p_wait_states) else $error("wait state altered a register");

	property p_tdo_enable;
		@(posedge tck) disable iff (sys_rst)
		ce_tck && $past(ce_tck) |-> (tdo_oe_n == !(dec.shift_ir || dec.shift_dr));
	endproperty
	a_tdo_enable: assert property (p_tdo_enable) else $error("data out driven outside shift states");

	property p_fuse_reset;
		@(posedge tck) disable iff (sys_rst)
		!fuse_tck && ce_tck |=> (state == ST_RESET);
	endproperty
	a_fuse_reset: assert property (p_fuse_reset) else $error("controller left reset with fuse clear");

	property p_pullup;
		@(posedge clock) disable iff (sys_rst)
		$rose(fuse_sys) && clk_en |=> tap_pullup_en && !tap_pins_released;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-ups not enabled with fuse set");

endmodule : jtp_tap

`default_nettype wire

// ===== test/jtp_host.sv
/*
 Model of the external test controller: drives the test clock, mode
 select and data in, samples data out just before each rising edge.
 Assumes data out is resolved by the bench; test clock stands still
 low between frames.
*/
`timescale 1ns/10ps
`default_nettype none

module jtp_host (
	output var  logic tck,
	output var  logic tms,
	output var  logic tdi,
	input  wire logic tdo
);
	// ----------------------------------------
	// one test clock period, 64 ns
	// ----------------------------------------
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	task automatic bit_go(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#32;
		q   = tdo;
		tck = 1'b1;
		#32;
		tck = 1'b0;
	endtask : bit_go

	// mode select walk, bit 0 first
	task automatic walk(input logic [7:0] seq, input int n);
		logic q;
		for (int i = 0; i < n; i++) begin
			bit_go(seq[i], 1'b0, q);
		end
	endtask : walk

	// lsb first, mode select high with the last bit
	task automatic shift(input logic [63:0] din, input int n, output logic [63:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			bit_go(i == n - 1, din[i], dout[i]);
		end
	endtask : shift
endmodule : jtp_host

`default_nettype wire

// ===== test/testbench.sv
/*
 Self-checking bench of the test access port top.
 Assumes the core files compiled before it; clk_en tied high.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
	import jtp_pkg::*;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam logic [31:0] ID_V = 32'h1234_ABCD; // arbitrary value
	logic       clock, sys_rst, fuse, tdo_out, tdo_oe_n, tdo_last;
	logic       pull_en, released, test_mode, in_reset, in_idle;
	logic [7:0] bsr_pins, bsr_drive;
	logic [3:0] instr_active;
	wire        tck, tms, tdi, tdo_w;
	logic [63:0] out;
	int         n_mismatch, n_tests, cycles;

	jtp_tap #(.ID_CODE(ID_V)) i_dut (
		.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .test_port_enable_fuse(fuse),
		.tck(tck), .tms(tms), .tdi(tdi), .bsr_pins(bsr_pins), .tdo_out(tdo_out),
		.tdo_oe_n(tdo_oe_n), .tap_pullup_en(pull_en), .tap_pins_released(released),
		.instr_active(instr_active), .bsr_drive(bsr_drive), .boundary_test_mode(test_mode),
		.tap_in_reset(in_reset), .run_idle_active(in_idle)
	);
	jtp_host h (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));

	// released data out shows the inverse of its last value
	always @(tdo_out or tdo_oe_n) begin
		if (tdo_oe_n === 1'b0) begin
			tdo_last = tdo_out;
		end
	end
	assign tdo_w = (tdo_oe_n === 1'b0) ? tdo_out : ~tdo_last;

	// ----------------------------------------
	// clock, timeout, helpers
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic settle();
		repeat (6) @(negedge clock);
	endtask : settle

	task automatic ir_scan(input logic [3:0] code);
		h.walk(8'h03, 4);
		h.shift({60'h0, code}, 4, out);
		h.walk(8'h01, 3);
		settle();
	endtask : ir_scan

	task automatic dr_scan(input logic [63:0] din, input int n);
		h.walk(8'h01, 3);
		h.shift(din, n, out);
		h.walk(8'h01, 3);
		settle();
	endtask : dr_scan

	task automatic end_of_test();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk(in_reset, 1'b1, "reset state");
		chk(instr_active, 4'h1, "reset instr");
		chk({tdo_oe_n, released, pull_en}, 3'b110, "reset pins");
		chk(bsr_drive, 8'h00, "reset drive");
	endtask : t_reset

	task automatic t_ir();
		chk({pull_en, released}, 2'b10, "fuse on");
		h.walk(8'h03, 4);
		h.shift(64'h2, 4, out);
		chk(out[3:0], 4'h1, "ir capture");
		h.walk(8'h01, 3);
		settle();
		chk(instr_active, 4'h2, "ir update");
		chk({in_idle, tdo_oe_n}, 2'b11, "idle");
	endtask : t_ir

	task automatic t_id();
		h.walk(8'h03, 4);
		h.shift(64'h1, 4, out);
		h.walk(8'h03, 4);
		h.shift(64'h0, 32, out);
		chk(out[31:0], ID_V, "id value");
		h.walk(8'h01, 2);
		settle();
	endtask : t_id

	task automatic t_byp();
		logic [3:0] codes [3] = '{4'hF, 4'h8, 4'h3};
		foreach (codes[i]) begin
			ir_scan(codes[i]);
			dr_scan(64'hB6, 8);
			chk(out[7:0], 8'h6C, "bypass");
		end
	endtask : t_byp

	task automatic t_bsr();
		@(negedge clock);
		bsr_pins = 8'hA5;
		ir_scan(4'h0);
		chk(test_mode, 1'b1, "extest mode");
		h.walk(8'h01, 3);
		h.shift(64'h3C, 8, out);
		chk(out[7:0], 8'hA5, "bsr capture");
		h.walk(8'h00, 3);
		settle();
		chk(bsr_drive, 8'h00, "pause holds");
		h.walk(8'h03, 3);
		settle();
		chk(bsr_drive, 8'h3C, "bsr update");
		ir_scan(4'h2);
		chk(test_mode, 1'b0, "sample mode");
	endtask : t_bsr

	task automatic t_five();
		h.walk(8'h01, 3);
		h.walk(8'h3F, 6);
		settle();
		chk({in_reset, instr_active}, 5'h11, "five ones");
		h.walk(8'h00, 1);
	endtask : t_five

	task automatic t_fuse();
		@(negedge clock);
		fuse = 1'b0;
		settle();
		chk({pull_en, released}, 2'b01, "fuse off");
		h.walk(8'h03, 4);
		h.walk(8'h00, 2);
		settle();
		chk({in_reset, tdo_oe_n}, 2'b11, "held reset");
		@(negedge clock);
		fuse = 1'b1;
		settle();
		h.walk(8'h3F, 8);
		settle();
		chk(in_idle, 1'b1, "back to idle");
	endtask : t_fuse

	task automatic t_sysrst();
		ir_scan(4'h0);
		chk(test_mode, 1'b1, "extest again");
		@(negedge clock);
		sys_rst = 1'b1;
		settle();
		t_reset();
		chk(test_mode, 1'b0, "reset mode");
		@(negedge clock);
		sys_rst = 1'b0;
		settle();
		h.walk(8'h3F, 8);
		settle();
		chk({in_reset, in_idle}, 2'b01, "after reset");
	endtask : t_sysrst

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_rst    = 1'b1;
		fuse       = 1'b1;
		bsr_pins   = 8'h00;
		tdo_last   = 1'b0;
		n_mismatch = 0;
		n_tests    = 0;
		cycles     = 0;
		repeat (11) @(negedge clock);
		t_reset();
		@(negedge clock);
		sys_rst = 1'b0;
		settle();
		h.walk(8'h3F, 7);
		settle();
		t_ir();
		t_id();
		t_byp();
		t_bsr();
		t_five();
		t_fuse();
		t_sysrst();
		end_of_test();
	end
endmodule : testbench

`default_nettype wire
